/* dprhc_host.sv */
// dprhc_host: apb-commanded controller that drives one port of a dual-port static ram
// assumes one ram port on the pins below; apb master on pclk; no other driver on the port
`timescale 1ns/10ps

// Functional notes
// [R1] ram holds 8K words of 8 or 9 bits, both ports reach all
// [R2] write happens only while selecting enable and write strobe are both low
// [R3] controller keeps write strobe high whenever the address changes
// [R4] ram floats its data pins during a write even with output drive low
// [R5] memory read asserts port enable on taking the command; the controller lowers output drive only after the busy settle count
// [R6] semaphores use token select with port enable high, memory the reverse
// [R7] each semaphore read is strobed separately, never by continuous selection
// [R8] port enable stays high through semaphore write and its read-back
// [R9] simultaneous semaphore requests within the window give it to one port
// [R10] reads of a location being written are unreliable until flowthrough passes
// [R11] a deselected port powers down and floats its data pins
// [R12] left write to 1FFF sets the right mailbox flag
// [R13] right read of 1FFF clears the right mailbox flag
// [R14] right write to 1FFE sets the left mailbox flag
// [R15] left read of 1FFE clears the left mailbox flag
// [R16] matching addresses within the priority window are granted to one port
// [R17] violating the priority window still busies exactly one port
// [R18] busy goes to the loser after address match or late enable
// [R19] role select high drives busy lines, low takes them as inputs
// [R20] writes wait until the busy input has settled
// [R21] a master ram drives busy both ways without pull-up
// [R22] eight semaphore latches selected by the three low address lines
// [R23] semaphore write uses bit 0: zero requests, one releases
// [R24] mailbox words are otherwise ordinary user memory
// [R25] requests far enough apart are granted to the earlier port
module dprhc_host
  import dprhc_pkg::*;
(
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [dprhc_pkg::APB_AW-1:0] paddr,
  input  wire logic [dprhc_pkg::APB_DW-1:0] pwdata,
  output logic      [dprhc_pkg::APB_DW-1:0] prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic      [dprhc_pkg::RAM_AW-1:0] addr_o,
  output logic                              port_enable_n,
  output logic                              token_select_n,
  output logic                              write_strobe_n,
  output logic                              output_drive_n,
  output logic      [dprhc_pkg::RAM_DW-1:0] data_o,
  output logic                              data_oe,
  input  wire logic [dprhc_pkg::RAM_DW-1:0] data_i,
  input  wire logic                         busy_n,
  input  wire logic                         mailbox_flag_n
);
  import dprhc_pkg::*;

  dprhc_regs_t  r_r;
  dprhc_regs_t  r_nxt;
  dprhc_sync_if sync ();

  dprhc_sync u_sync (
    .pclk           (pclk),
    .presetn        (presetn),
    .busy_n         (busy_n),
    .mailbox_flag_n (mailbox_flag_n),
    .data_i         (data_i),
    .sync           (sync.src)
  );

  function automatic logic is_sem(input dprhc_op_t op);
    is_sem = (op == OP_SEM_RD) || (op == OP_SEM_WR);
  endfunction

  function automatic logic is_wr(input dprhc_op_t op);
    is_wr = (op == OP_MEM_WR) || (op == OP_SEM_WR);
  endfunction

  always_comb begin
    r_nxt = r_r;

    // apb slave: answer in the first access cycle
    if (psel && !penable) begin
      r_nxt.pready  = 1'b1;
      r_nxt.pslverr = 1'b0;
      r_nxt.prdata  = '0;
      case (paddr)
        OFS_CMD: begin
          r_nxt.prdata[RAM_AW-1:0]           = r_r.addr;
          r_nxt.prdata[CMD_OP_LSB+1:CMD_OP_LSB] = r_r.op;
          // a new command cannot overtake one in flight
          r_nxt.pslverr = pwrite && (r_r.st != ST_IDLE);
        end
        OFS_WDATA: begin
          r_nxt.prdata[RAM_DW-1:0] = r_r.wdata;
        end
        OFS_STATUS: begin
          r_nxt.prdata[ST_ACTIVE]  = (r_r.st != ST_IDLE);
          r_nxt.prdata[ST_DONE]    = r_r.done;
          r_nxt.prdata[ST_WAITED]  = r_r.waited;
          r_nxt.prdata[ST_MBOX]    = !sync.mbox_n;
          r_nxt.prdata[ST_BUSYPIN] = !sync.busy_n;
          r_nxt.prdata[ST_RDATA_LSB+RAM_DW-1:ST_RDATA_LSB] = r_r.rdata;
        end
        default: begin
          r_nxt.pslverr = 1'b1;
        end
      endcase
    end else if (psel && penable && r_r.pready) begin
      r_nxt.pready = 1'b0;
      if (pwrite && !r_r.pslverr) begin
        if (paddr == OFS_WDATA) begin
          r_nxt.wdata = pwdata[RAM_DW-1:0];
        end else if (paddr == OFS_CMD) begin
          // address moves only here, with all strobes high
          r_nxt.addr   = pwdata[RAM_AW-1:0]; // [R3]
          r_nxt.op     = dprhc_op_t'(pwdata[CMD_OP_LSB+1:CMD_OP_LSB]);
          r_nxt.done   = 1'b0;
          r_nxt.waited = 1'b0;
          r_nxt.st     = ST_SETUP;
          r_nxt.cnt    = SET_CYC;
          // exactly one selecting enable per access
          r_nxt.pe_n = is_sem(r_nxt.op); // [R6]
          r_nxt.ts_n = !is_sem(r_nxt.op); // [R6]
        end
      end
    end else begin
      r_nxt.pready  = 1'b0;
      r_nxt.pslverr = 1'b0;
    end

    case (r_r.st)
      ST_IDLE: begin
        // a command taken this cycle has just loaded the busy settle count
        if (r_nxt.st == ST_IDLE) begin
          r_nxt.cnt = 3'h0;
        end
      end
      ST_SETUP: begin
        if (!is_sem(r_r.op) && !sync.busy_n) begin
          // lost arbitration: hold the request and restart settling
          r_nxt.waited = 1'b1; // [R20]
          r_nxt.cnt    = SET_CYC;
        end else if (r_r.cnt > 3'h1) begin
          r_nxt.cnt = r_r.cnt - 3'h1; // [R20]
        end else if (is_wr(r_r.op)) begin
          // output drive stays high so the ram pins are already floating
          r_nxt.ws_n = 1'b0; // [R2]
          r_nxt.doe  = 1'b1;
          r_nxt.dout = r_r.wdata;
          r_nxt.st   = ST_WSTRB;
          r_nxt.cnt  = PWE_CYC;
        end else begin
          r_nxt.od_n = 1'b0; // [R5]
          r_nxt.st   = ST_READ;
          r_nxt.cnt  = ACC_CYC;
        end
      end
      ST_WSTRB: begin
        if (r_r.cnt > 3'h1) begin
          r_nxt.cnt = r_r.cnt - 3'h1;
        end else begin
          // strobe rises first and ends the write; enable and data follow
          r_nxt.ws_n = 1'b1; // [R2]
          r_nxt.st   = ST_WEND;
          r_nxt.cnt  = HA_CYC;
        end
      end
      ST_WEND: begin
        if (r_r.cnt > 3'h1) begin
          r_nxt.cnt = r_r.cnt - 3'h1;
        end else begin
          r_nxt.doe  = 1'b0;
          r_nxt.ts_n = 1'b1;
          r_nxt.pe_n = 1'b1;
          if (r_r.op == OP_SEM_WR) begin
            r_nxt.st  = ST_SOP; // [R8]
            r_nxt.cnt = SOP_CYC;
          end else begin
            r_nxt.st   = ST_IDLE;
            r_nxt.done = 1'b1;
          end
        end
      end
      ST_SOP: begin
        if (r_r.cnt > 3'h1) begin
          r_nxt.cnt = r_r.cnt - 3'h1;
        end else begin
          // read-back: fresh token strobe, port enable never touched
          r_nxt.op   = OP_SEM_RD; // [R7]
          r_nxt.ts_n = 1'b0; // [R8]
          r_nxt.st   = ST_SETUP;
          r_nxt.cnt  = SET_CYC;
        end
      end
      ST_READ: begin
        if (r_r.cnt > 3'h1) begin
          r_nxt.cnt = r_r.cnt - 3'h1;
        end else begin
          r_nxt.rdata = sync.data;
          r_nxt.od_n  = 1'b1;
          // every semaphore read ends its own strobe
          r_nxt.ts_n  = 1'b1; // [R7]
          r_nxt.pe_n  = 1'b1;
          r_nxt.st    = ST_IDLE;
          r_nxt.done  = 1'b1;
        end
      end
      default: begin
        r_nxt = REGS_RST;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= REGS_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign prdata         = r_r.prdata;
  assign pready         = r_r.pready;
  assign pslverr        = r_r.pslverr;
  assign addr_o         = r_r.addr;
  assign port_enable_n  = r_r.pe_n;
  assign token_select_n = r_r.ts_n;
  assign write_strobe_n = r_r.ws_n;
  assign output_drive_n = r_r.od_n;
  assign data_o         = r_r.dout;
  assign data_oe        = r_r.doe;
endmodule // dprhc_host

/* dprhc_pkg.sv */
// dprhc_pkg: constants, types and register map of the dual-port ram host controller
// assumes a single 20 MHz apb clock domain; ram pins are asynchronous to it
package dprhc_pkg;

  localparam int RAM_AW = 13;
  localparam int RAM_DW = 9;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int SYNC_STAGES = 2;

  // clock period and ram timing, ns
  localparam int CLK_NS     = 50;
  localparam int T_PWE_NS   = 40;  // write pulse width, least
  localparam int T_HA_NS    = 2;   // address hold from write end, least
  localparam int T_SOP_NS   = 20;  // token select high between write and read-back, least
  localparam int T_ACC_NS   = 55;  // enable to read data valid, waited in full
  localparam int T_BUSY_NS  = 30;  // busy settle after address and enable, waited in full

  localparam logic [2:0] PWE_CYC  = 3'((T_PWE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] HA_CYC   = 3'((T_HA_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] SOP_CYC  = 3'((T_SOP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] ACC_CYC  = 3'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [2:0] SET_CYC  = 3'((T_BUSY_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);

  // register byte offsets
  localparam logic [APB_AW-1:0] OFS_CMD    = 8'h00;
  localparam logic [APB_AW-1:0] OFS_WDATA  = 8'h04;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h08;

  // field positions
  localparam int CMD_OP_LSB   = 16;
  localparam int ST_ACTIVE    = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_WAITED    = 2;
  localparam int ST_MBOX      = 3;
  localparam int ST_BUSYPIN   = 4;
  localparam int ST_RDATA_LSB = 16;

  typedef enum logic [1:0] {
    OP_MEM_RD = 2'b00,
    OP_MEM_WR = 2'b01,
    OP_SEM_RD = 2'b10,
    OP_SEM_WR = 2'b11
  } dprhc_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WSTRB = 3'b010,
    ST_WEND  = 3'b011,
    ST_SOP   = 3'b100,
    ST_READ  = 3'b101
  } dprhc_state_t;

  typedef struct packed {
    dprhc_state_t       st;
    logic [2:0]         cnt;
    dprhc_op_t          op;
    logic [RAM_AW-1:0]  addr;
    logic [RAM_DW-1:0]  wdata;
    logic [RAM_DW-1:0]  rdata;
    logic               done;
    logic               waited;
    logic               pe_n;
    logic               ts_n;
    logic               ws_n;
    logic               od_n;
    logic               doe;
    logic [RAM_DW-1:0]  dout;
    logic               pready;
    logic               pslverr;
    logic [APB_DW-1:0]  prdata;
  } dprhc_regs_t;

  localparam dprhc_regs_t REGS_RST = '{
    st: ST_IDLE, cnt: 3'h0, op: OP_MEM_RD, addr: 13'h0000, wdata: 9'h000,
    rdata: 9'h000, done: 1'b0, waited: 1'b0, pe_n: 1'b1, ts_n: 1'b1,
    ws_n: 1'b1, od_n: 1'b1, doe: 1'b0, dout: 9'h000, pready: 1'b0,
    pslverr: 1'b0, prdata: 32'h0000_0000};

endpackage

/* dprhc_sync_if.sv */
// dprhc_sync_if: synchronised ram pin levels from the input stage to the controller
// assumes both ends run on pclk
`timescale 1ns/10ps
interface dprhc_sync_if;
  logic                         busy_n;
  logic                         mbox_n;
  logic [dprhc_pkg::RAM_DW-1:0] data;
  modport src (output busy_n, output mbox_n, output data);
  modport dst (input busy_n, input mbox_n, input data);
endinterface

/* dprhc_sync.sv */
// dprhc_sync: two-flop synchronisers for the ram pins read by the controller
// assumes pins are asynchronous to pclk; data is only used once it has stood still
`timescale 1ns/10ps
module dprhc_sync
  import dprhc_pkg::*;
(
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         busy_n,
  input  wire logic                         mailbox_flag_n,
  input  wire logic [dprhc_pkg::RAM_DW-1:0] data_i,
  dprhc_sync_if.src                         sync
);
  typedef struct packed {
    logic [RAM_DW+1:0] s1;
    logic [RAM_DW+1:0] s2;
  } dprhc_sync_t;

  dprhc_sync_t r_r;
  dprhc_sync_t r_nxt;

  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = {busy_n, mailbox_flag_n, data_i};
    r_nxt.s2 = r_r.s1;
  end

  // idle levels of the active-low pins are high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '{s1: 11'h600, s2: 11'h600};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign sync.busy_n = r_r.s2[RAM_DW+1];
  assign sync.mbox_n = r_r.s2[RAM_DW];
  assign sync.data   = r_r.s2[RAM_DW-1:0];
endmodule // dprhc_sync

/* dprhc_host_assertions.sv */
// dprhc_host_assertions: pin and apb timing checks on dprhc_host
// assumes only the top ports are seen; bound below
`timescale 1ns/10ps
module dprhc_host_assertions (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pready,
  input wire logic [dprhc_pkg::RAM_AW-1:0] addr_o,
  input wire logic                         port_enable_n,
  input wire logic                         token_select_n,
  input wire logic                         write_strobe_n,
  input wire logic                         output_drive_n,
  input wire logic                         data_oe,
  input wire logic                         busy_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  one_select_a: assert property (!(!port_enable_n && !token_select_n))
    else $error("both selects low");
  strobe_sel_a: assert property (!write_strobe_n |-> !port_enable_n || !token_select_n)
    else $error("strobe without select");
  strobe_len_a: assert property ($fell(write_strobe_n) |-> data_oe ##1 write_strobe_n)
    else $error("bad strobe pulse");
  addr_hold_a: assert property ($changed(addr_o) |-> write_strobe_n && $past(write_strobe_n))
    else $error("address moved under strobe");
  drive_off_a: assert property (data_oe |-> output_drive_n)
    else $error("host drives with output on");
  read_len_a: assert property ($fell(output_drive_n)
    |-> !output_drive_n [*4] ##1 output_drive_n)
    else $error("bad read pulse");
  idle_pins_a: assert property (port_enable_n && token_select_n
    |-> output_drive_n && write_strobe_n)
    else $error("pins active while deselected");
  sem_gap_a: assert property ($rose(write_strobe_n) && !token_select_n
    |-> ##1 token_select_n ##1 !token_select_n)
    else $error("no token select gap");
  busy_wait_a: assert property ($fell(write_strobe_n) && !port_enable_n
    |-> !(!$past(busy_n, 1) && !$past(busy_n, 2) && !$past(busy_n, 3) && !$past(busy_n, 4)))
    else $error("write under busy");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bad pready");
endmodule // dprhc_host_assertions

bind dprhc_host dprhc_host_assertions dprhc_host_assertions_i (.pclk, .presetn, .psel, .penable,
  .pready, .addr_o, .port_enable_n, .token_select_n, .write_strobe_n, .output_drive_n, .data_oe,
  .busy_n);

/* dprhc_ram_model.sv */
// dprhc_ram_model: behavioural left port of the dual-port ram
// assumes far_* inputs and clash stand in for the right port
`timescale 1ns/10ps
module dprhc_ram_model (
  input  wire logic [12:0] addr,
  input  wire logic        pe_n,
  input  wire logic        ts_n,
  input  wire logic        ws_n,
  input  wire logic        od_n,
  input  wire logic [8:0]  din,
  input  wire logic        din_oe,
  output logic      [8:0]  dq,
  output logic             busy_n,
  output logic             mbox_n,
  output logic             far_flag_n,
  input  wire logic        far_post,
  input  wire logic        far_clr,
  input  wire logic [7:0]  far_take,
  input  wire logic        clash
);
  logic [8:0] mem [8192];
  logic [7:0] req = 8'h00;
  logic [8:0] q = 9'h000;
  logic       near_n = 1'h1;
  logic       far_n = 1'h1;
  logic       rd;
  // host ends writes by the strobe; far_clr is the far port reading 1FFF
  always @(posedge ws_n or posedge far_clr) begin
    if (far_clr) begin
      far_n <= 1'h1;
    end else begin
      if (!pe_n && ts_n) begin
        mem[addr] <= din;
        if (addr == 13'h1FFF) far_n <= 1'h0;
      end
      if (!ts_n && pe_n) req[addr[2:0]] <= ~din[0];
    end
  end
  always @(posedge far_post or negedge od_n) begin
    if (far_post) near_n <= 1'h0;
    else if (!pe_n && addr == 13'h1FFE) near_n <= 1'h1;
  end
  assign mbox_n = near_n;
  assign far_flag_n = far_n;
  assign rd = !od_n && ws_n && (pe_n ^ ts_n);
  // words change only as a write ends, so no read sees a half-written word
  // far side release grants a pending request at once; far_take wins whenever set, whichever side asked first
  always @* if (rd) q = pe_n ? {9{~(req[addr[2:0]] & ~far_take[addr[2:0]])}} : mem[addr];
  // released bus shows the inverse of its last value
  assign dq = din_oe ? din : rd ? q : ~q;
  // master ram drives busy both ways; clash marks the far port as first, so this port loses
  assign busy_n = !(clash && !pe_n);
endmodule // dprhc_ram_model

/* testbench.sv */
// testbench: apb-driven scenarios for dprhc_host against the ram model
// assumes dprhc_pkg offsets and status fields
`timescale 1ns/10ps
module testbench;
  import dprhc_pkg::*;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, st, q;
  logic [12:0] addr_o;
  logic [8:0]  data_o, dq;
  logic [7:0]  far_take = 8'h00;
  logic        pready, pslverr, pe_n, ts_n, ws_n, od_n, data_oe, busy_n, mbox_n, far_flag_n, e;
  logic        far_post = 1'h0;
  logic        far_clr = 1'h0;
  logic        clash = 1'h0;
  int          err_total = 0;
  int          comparisons = 0;

  always #25 pclk = ~pclk;

  dprhc_host dprhc_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .addr_o, .port_enable_n(pe_n), .token_select_n(ts_n),
    .write_strobe_n(ws_n), .output_drive_n(od_n), .data_o, .data_oe, .data_i(dq), .busy_n,
    .mailbox_flag_n(mbox_n));
  dprhc_ram_model dprhc_ram_model_i (.addr(addr_o), .pe_n, .ts_n, .ws_n, .od_n, .din(data_o),
    .din_oe(data_oe), .dq, .busy_n, .mbox_n, .far_flag_n, .far_post, .far_clr, .far_take, .clash);

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask

  function automatic logic [31:0] rdv;
    return {23'h0, st[24:16]};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    r = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      err_total++;
      close_out;
    end
  endtask

  task automatic waitdone;
    int n;
    n = 0;
    do begin
      apb(1'h0, OFS_STATUS, 32'h0, st, e);
      n++;
    end while (st[ST_DONE] !== 1'h1 && n < 100);
    if (st[ST_DONE] !== 1'h1) begin
      err_total++;
      close_out;
    end
  endtask

  task automatic cmd(input logic [1:0] op, input logic [12:0] a, input logic [8:0] d);
    apb(1'h1, OFS_WDATA, {23'h0, d}, q, e);
    apb(1'h1, OFS_CMD, {14'h0, op, 3'h0, a}, q, e);
    waitdone;
  endtask

  task automatic t_reset;
    chk({27'h0, pe_n, ts_n, ws_n, od_n, data_oe}, 32'h0000_001E);
    apb(1'h0, OFS_STATUS, 32'h0, st, e);
    chk(st, 32'h0);
  endtask

  task automatic t_mem;
    cmd(OP_MEM_WR, 13'h0000, 9'h1FF);
    cmd(OP_MEM_WR, 13'h1FFD, 9'h0AA);
    cmd(OP_MEM_RD, 13'h0000, 9'h000);
    chk(rdv(), 32'h1FF);
    cmd(OP_MEM_RD, 13'h1FFD, 9'h000);
    chk(rdv(), 32'h0AA);
  endtask

  task automatic t_mbox;
    cmd(OP_MEM_WR, 13'h1FFF, 9'h03C);
    chk({31'h0, far_flag_n}, 32'h0);
    cmd(OP_MEM_WR, 13'h1FFE, 9'h0C3);
    @(posedge pclk) far_post <= 1'h1;
    @(posedge pclk) far_post <= 1'h0;
    repeat (4) @(posedge pclk);
    apb(1'h0, OFS_STATUS, 32'h0, st, e);
    chk({31'h0, st[ST_MBOX]}, 32'h1);
    cmd(OP_MEM_RD, 13'h1FFE, 9'h000);
    chk(rdv(), 32'h0C3);
    chk({31'h0, st[ST_MBOX]}, 32'h0);
    cmd(OP_MEM_RD, 13'h1FFF, 9'h000);
    chk(rdv(), 32'h03C);
    @(posedge pclk) far_clr <= 1'h1;
    @(posedge pclk) far_clr <= 1'h0;
    chk({31'h0, far_flag_n}, 32'h1);
  endtask

  task automatic t_sem;
    far_take <= 8'hAA;
    for (int i = 0; i < 8; i++) begin
      cmd(OP_SEM_WR, 13'h1FF8 | 13'(i), 9'h000);
      chk(rdv(), far_take[i] ? 32'h1FF : 32'h0);
      cmd(OP_SEM_WR, 13'h1FF8 | 13'(i), 9'h001);
      chk(rdv(), 32'h1FF);
    end
    cmd(OP_SEM_WR, 13'h0001, 9'h000);
    far_take <= 8'h00;
    cmd(OP_SEM_RD, 13'h0001, 9'h000);
    chk(rdv(), 32'h0);
  endtask

  task automatic t_busy;
    clash <= 1'h1;
    fork
      begin
        repeat (14) @(posedge pclk);
        clash <= 1'h0;
      end
    join_none
    cmd(OP_MEM_WR, 13'h0100, 9'h155);
    chk({31'h0, st[ST_WAITED]}, 32'h1);
    cmd(OP_MEM_RD, 13'h0100, 9'h000);
    chk(rdv(), 32'h155);
  endtask

  task automatic t_err;
    apb(1'h0, 8'h0C, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'h1, OFS_CMD, 32'h0000_0000, q, e);
    apb(1'h1, OFS_CMD, 32'h0001_0000, q, e);
    chk({31'h0, e}, 32'h1);
    waitdone;
    chk(rdv(), 32'h1FF);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_mem;
    t_mbox;
    t_sem;
    t_busy;
    t_err;
    close_out;
  end
endmodule // testbench
